// ==== core/scc_pkg.sv ====
// Constants and types shared by the capture control logic.
package scc_pkg;

	// ************************************************************
	// Register indices (byte address is four times the index)
	// ************************************************************
	localparam int ADDR_W = 12;
	localparam int IDX_W = 10;
	localparam logic [IDX_W-1:0] IDX_CLK_STATUS = 10'h11c;
	localparam logic [IDX_W-1:0] IDX_CAPT_CTRL = 10'h120;
	localparam logic [IDX_W-1:0] IDX_IGN_COUNT = 10'h121;
	localparam logic [IDX_W-1:0] IDX_SKEW_WIN = 10'h122;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h130;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h131;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int CLK_DET_BIT = 0;
	localparam int CTRL_FLAG_RST_BIT = 6;
	localparam int CTRL_TRANS_BIT = 4;
	localparam int CTRL_EDGE_BIT = 3;
	localparam int CTRL_MODE_LSB = 1;
	localparam int IGN_LSB = 0;
	localparam int SKEW_POS_LSB = 0;
	localparam int SKEW_NEG_LSB = 2;
	localparam int EV_CAPT_BIT = 0;
	localparam int EV_SKEW_BIT = 1;
	localparam int EV_SKIP_BIT = 2;
	localparam int EV_NUM = 3;

	// ************************************************************
	// Reset values and writable bits
	// ************************************************************
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] IGN_RST = 8'h00;
	localparam logic [7:0] SKEW_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'h5e;
	localparam logic [7:0] IGN_WMASK = 8'h0f;
	localparam logic [7:0] SKEW_WMASK = 8'h0f;
	localparam logic [7:0] IRQ_WMASK = 8'h07;

	// ************************************************************
	// Encodings
	// ************************************************************
	typedef enum logic [1:0] {
		MODE_OFF = 2'b00,
		MODE_CONT = 2'b01,
		MODE_NSHOT = 2'b10,
		MODE_NSHOT_ALT = 2'b11
	} scc_mode_type;

	typedef enum logic [1:0] {
		NS_IDLE = 2'b00,
		NS_SKIP = 2'b01,
		NS_DONE = 2'b11
	} scc_nshot_type;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== core/scc_sync2.sv ====
// Two-flop level synchroniser.
module scc_sync2 (
	input wire logic clk, // Destination clock
	input wire logic rst, // Asynchronous reset, active high
	input wire logic d, // Asynchronous level
	output logic q // Synchronised level
);
	logic meta_ff;
	logic sync_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end else begin
			meta_ff <= d;
			sync_ff <= meta_ff;
		end
	end

	assign q = sync_ff;
endmodule

// ==== core/scc_top.sv ====
// Capture control for the timing reference, with AXI4-Lite registers.
// Functional notes
// R1: A read-only bit shows 1 while an input clock is detected and 0 otherwise.
// R2: While the flag reset bit is 1 the status flags are held cleared.
// R3: The transition select bit picks rising (0) or falling (1) reference transitions.
// R4: The edge select bit samples the reference on the rising (0) or falling (1) clock edge.
// R5: The mode field disables (00), captures every transition (01) or does N-shot capture.
// R6: In N-shot mode the ignore count gives how many transitions are skipped before one is used.
// R7: Software must select N-shot mode for the ignore count to take effect.
// R8: The positive skew window ignores transitions up to 0..3 clocks late of the expected one.
// R9: The negative skew window ignores transitions up to 0..3 clocks early of the expected one.
// R10: The reference input is synchronised before any edge, window or count logic sees it.
module scc_top
	import scc_pkg::*;
#(
	parameter int PER_W = 16
) (
	input wire logic MCLK, // Sample clock
	input wire logic RST, // Asynchronous reset, active high
	input wire logic SYSREF, // Timing reference pin
	input wire logic CLK_DET, // Input clock present pin
	input wire logic [ADDR_W-1:0] AWADDR, // Write address
	input wire logic AWVALID, // Write address valid
	output logic AWREADY, // Write address ready
	input wire logic [31:0] WDATA, // Write data
	input wire logic [3:0] WSTRB, // Write strobes
	input wire logic WVALID, // Write data valid
	output logic WREADY, // Write data ready
	output logic [1:0] BRESP, // Write response
	output logic BVALID, // Write response valid
	input wire logic BREADY, // Write response ready
	input wire logic [ADDR_W-1:0] ARADDR, // Read address
	input wire logic ARVALID, // Read address valid
	output logic ARREADY, // Read address ready
	output logic [31:0] RDATA, // Read data
	output logic [1:0] RRESP, // Read response
	output logic RVALID, // Read data valid
	input wire logic RREADY, // Read data ready
	output logic IRQ // Interrupt, high while an unmasked flag is set
);
	// ************************************************************
	// Declarations
	// ************************************************************
	logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff, irq_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	logic aw_full_ff, w_full_ff;
	logic [ADDR_W-1:0] aw_addr_ff;
	logic [7:0] wdata_ff;
	logic wstrb0_ff;
	logic [7:0] ctrl_ff, ign_ff, skew_ff, mask_ff;
	logic [EV_NUM-1:0] stat_ff, nxt_stat, ev, clr;
	logic clk_det_s, rise_s, fall_cap_ff, fall_s, sel_raw, sref_lvl, prev_ff, edge_det;
	logic [PER_W-1:0] cnt_ff, ref_ff;
	logic seen_ff, ref_valid_ff, qual, skew_ign, use_edge, ev_capt, ev_skip;
	logic [3:0] skip_cnt_ff;
	scc_nshot_type ns_ff;
	scc_mode_type mode;
	logic do_write, flag_rst, trans_sel, edge_sel;
	logic [1:0] pos_win, neg_win;
	logic [3:0] ign_cnt;

	assign AWREADY = awready_ff;
	assign WREADY = wready_ff;
	assign BVALID = bvalid_ff;
	assign BRESP = bresp_ff;
	assign ARREADY = arready_ff;
	assign RVALID = rvalid_ff;
	assign RDATA = rdata_ff;
	assign RRESP = rresp_ff;
	assign IRQ = irq_ff;

	assign flag_rst = ctrl_ff[CTRL_FLAG_RST_BIT];
	assign trans_sel = ctrl_ff[CTRL_TRANS_BIT];
	assign edge_sel = ctrl_ff[CTRL_EDGE_BIT];
	assign mode = scc_mode_type'(ctrl_ff[CTRL_MODE_LSB +: 2]);
	assign ign_cnt = ign_ff[IGN_LSB +: 4];
	assign pos_win = skew_ff[SKEW_POS_LSB +: 2];
	assign neg_win = skew_ff[SKEW_NEG_LSB +: 2];

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	// ************************************************************
	// Functions
	// ************************************************************
	function automatic logic [IDX_W-1:0] reg_idx(input logic [ADDR_W-1:0] a);
		reg_idx = a[ADDR_W-1:2];
	endfunction

	function automatic logic idx_mapped(input logic [IDX_W-1:0] i);
		idx_mapped = (i == IDX_CLK_STATUS) || (i == IDX_CAPT_CTRL) ||
			(i == IDX_IGN_COUNT) || (i == IDX_SKEW_WIN) ||
			(i == IDX_IRQ_STATUS) || (i == IDX_IRQ_MASK);
	endfunction

	// True when the distance is off the expected one but inside the window
	function automatic logic in_skew(input logic [PER_W-1:0] d, input logic [PER_W-1:0] r,
		input logic [1:0] p, input logic [1:0] n);
		logic [PER_W:0] dd, lo, hi;
		dd = {1'b0, d};
		lo = {1'b0, r} - {{(PER_W-1){1'b0}}, n};
		hi = {1'b0, r} + {{(PER_W-1){1'b0}}, p};
		in_skew = (d != r) && (r >= {{(PER_W-2){1'b0}}, n}) && (dd >= lo) && (dd <= hi);
	endfunction

	// ************************************************************
	// Input synchronisation
	// ************************************************************
	scc_sync2 u_sync_clk (.clk(MCLK), .rst(RST), .d(CLK_DET), .q(clk_det_s));
	// R10: pin passes two flops
	scc_sync2 u_sync_rise (.clk(MCLK), .rst(RST), .d(SYSREF), .q(rise_s));

	// R4: falling edge capture
	always_ff @(negedge MCLK or posedge RST) begin
		if (RST) begin
			fall_cap_ff <= 1'b0;
		end else begin
			fall_cap_ff <= SYSREF;
		end
	end

	scc_sync2 u_sync_fall (.clk(MCLK), .rst(RST), .d(fall_cap_ff), .q(fall_s));

	// R4: edge select
	assign sel_raw = edge_sel ? fall_s : rise_s;
	// R3: polarity folds falling transitions onto rising ones
	assign sref_lvl = sel_raw ^ trans_sel;
	// Changing either select may fake one transition; set them while disabled
	assign edge_det = sref_lvl & ~prev_ff;

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			prev_ff <= 1'b0;
		end else begin
			prev_ff <= sref_lvl;
		end
	end

	// ************************************************************
	// Period tracking and skew window
	// ************************************************************
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			cnt_ff <= '0;
		end else if (edge_det) begin
			cnt_ff <= {{(PER_W-1){1'b0}}, 1'b1};
		end else if (cnt_ff != '1) begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	assign qual = edge_det && (mode != MODE_OFF);
	// R8: late edges inside the positive window are ignored
	// R9: early edges inside the negative window are ignored
	assign skew_ign = qual && ref_valid_ff && in_skew(cnt_ff, ref_ff, pos_win, neg_win);
	assign use_edge = qual && !skew_ign;

	// The expected period is relearned from every used edge except the first one after capture is enabled
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			seen_ff <= 1'b0;
			ref_valid_ff <= 1'b0;
			ref_ff <= '0;
		end else if (mode == MODE_OFF) begin
			seen_ff <= 1'b0;
			ref_valid_ff <= 1'b0;
		end else if (use_edge) begin
			seen_ff <= 1'b1;
			if (seen_ff) begin
				ref_ff <= cnt_ff;
				ref_valid_ff <= 1'b1;
			end
		end
	end

	// ************************************************************
	// Capture modes
	// ************************************************************
	// R5: continuous or N-shot capture
	assign ev_capt = use_edge && ((mode == MODE_CONT) ||
		((ns_ff == NS_SKIP) && (skip_cnt_ff == ign_cnt)));
	assign ev_skip = use_edge && (ns_ff == NS_SKIP) && (skip_cnt_ff != ign_cnt);

	// R7: ignore count is consumed only in N-shot mode
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			ns_ff <= NS_IDLE;
			skip_cnt_ff <= 4'h0;
		end else if (!mode[1]) begin
			ns_ff <= NS_IDLE;
			skip_cnt_ff <= 4'h0;
		end else begin
			case (ns_ff)
				NS_IDLE: begin
					ns_ff <= NS_SKIP;
					skip_cnt_ff <= 4'h0;
				end
				NS_SKIP: begin
					// R6: skip count transitions, then use one
					if (ev_capt) begin
						ns_ff <= NS_DONE;
					end else if (ev_skip) begin
						skip_cnt_ff <= skip_cnt_ff + 4'h1;
					end
				end
				NS_DONE: begin
					ns_ff <= NS_DONE;
				end
				default: begin
					ns_ff <= NS_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// Status flags and interrupt
	// ************************************************************
	always_comb begin
		ev = '0;
		ev[EV_CAPT_BIT] = ev_capt;
		ev[EV_SKEW_BIT] = skew_ign;
		ev[EV_SKIP_BIT] = ev_skip;
		clr = '0;
		if (do_write && wstrb0_ff && (reg_idx(aw_addr_ff) == IDX_IRQ_STATUS)) begin
			clr = wdata_ff[EV_NUM-1:0];
		end
		// A new event wins over a clear in the same cycle
		nxt_stat = (stat_ff & ~clr) | ev;
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			stat_ff <= '0;
		end else if (flag_rst) begin
			// R2: flags held in reset
			stat_ff <= '0;
		end else begin
			stat_ff <= nxt_stat;
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(stat_ff & mask_ff[EV_NUM-1:0]);
		end
	end

	// ************************************************************
	// AXI4-Lite write channel
	// ************************************************************
	assign do_write = aw_full_ff && w_full_ff && !bvalid_ff;

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			awready_ff <= 1'b0;
			aw_full_ff <= 1'b0;
			aw_addr_ff <= '0;
		end else if (AWVALID && awready_ff) begin
			awready_ff <= 1'b0;
			aw_full_ff <= 1'b1;
			aw_addr_ff <= AWADDR;
		end else if (do_write) begin
			aw_full_ff <= 1'b0;
		end else if (!aw_full_ff && !bvalid_ff) begin
			awready_ff <= 1'b1;
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			wready_ff <= 1'b0;
			w_full_ff <= 1'b0;
			wdata_ff <= 8'h00;
			wstrb0_ff <= 1'b0;
		end else if (WVALID && wready_ff) begin
			wready_ff <= 1'b0;
			w_full_ff <= 1'b1;
			wdata_ff <= WDATA[7:0];
			wstrb0_ff <= WSTRB[0];
		end else if (do_write) begin
			w_full_ff <= 1'b0;
		end else if (!w_full_ff && !bvalid_ff) begin
			wready_ff <= 1'b1;
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= idx_mapped(reg_idx(aw_addr_ff)) ? RESP_OKAY : RESP_SLVERR;
		end else if (BREADY) begin
			bvalid_ff <= 1'b0;
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			ctrl_ff <= CTRL_RST;
			ign_ff <= IGN_RST;
			skew_ff <= SKEW_RST;
			mask_ff <= MASK_RST;
		end else if (do_write && wstrb0_ff) begin
			case (reg_idx(aw_addr_ff))
				IDX_CAPT_CTRL: ctrl_ff <= wdata_ff & CTRL_WMASK;
				IDX_IGN_COUNT: ign_ff <= wdata_ff & IGN_WMASK;
				IDX_SKEW_WIN: skew_ff <= wdata_ff & SKEW_WMASK;
				IDX_IRQ_MASK: mask_ff <= wdata_ff & IRQ_WMASK;
				default: begin
				end
			endcase
		end
	end

	// ************************************************************
	// AXI4-Lite read channel
	// ************************************************************
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
			rresp_ff <= RESP_OKAY;
		end else if (ARVALID && arready_ff) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rresp_ff <= idx_mapped(reg_idx(ARADDR)) ? RESP_OKAY : RESP_SLVERR;
			rdata_ff <= '0;
			case (reg_idx(ARADDR))
				// R1: clock detect status
				IDX_CLK_STATUS: rdata_ff[CLK_DET_BIT] <= clk_det_s;
				IDX_CAPT_CTRL: rdata_ff[7:0] <= ctrl_ff;
				IDX_IGN_COUNT: rdata_ff[7:0] <= ign_ff;
				IDX_SKEW_WIN: rdata_ff[7:0] <= skew_ff;
				IDX_IRQ_STATUS: rdata_ff[EV_NUM-1:0] <= stat_ff;
				IDX_IRQ_MASK: rdata_ff[7:0] <= mask_ff;
				default: begin
				end
			endcase
		end else if (rvalid_ff && RREADY) begin
			rvalid_ff <= 1'b0;
		end else if (!rvalid_ff) begin
			arready_ff <= 1'b1;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	property p_clk_status;
		ARVALID && arready_ff && (reg_idx(ARADDR) == IDX_CLK_STATUS)
			|=> RVALID && (RDATA == {31'h0, $past(clk_det_s)});
	endproperty
	a_clk_status: assert property (p_clk_status) else $error("clock status read wrong"); // R1

	property p_flag_rst;
		flag_rst |=> (stat_ff == '0);
	endproperty
	a_flag_rst: assert property (p_flag_rst) else $error("flags not held in reset"); // R2

	property p_trans;
		edge_det |-> (sel_raw == !trans_sel) && ($past(sel_raw) == trans_sel || $changed(trans_sel));
	endproperty
	a_trans: assert property (p_trans) else $error("edge of wrong polarity"); // R3

	property p_rise_path;
		!edge_sel && !trans_sel && $stable(edge_sel) && $stable(trans_sel) && edge_det
			|-> $past(SYSREF, 2);
	endproperty
	a_rise_path: assert property (p_rise_path) else $error("rising sample path wrong"); // R10

	property p_edge_sel;
		edge_sel |-> (sel_raw == fall_s);
	endproperty
	a_edge_sel: assert property (p_edge_sel) else $error("falling edge not selected"); // R4

	property p_mode_off;
		(mode == MODE_OFF) |-> !ev_capt && !skew_ign && !ev_skip;
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("capture while disabled"); // R5

	property p_cont;
		(mode == MODE_CONT) && use_edge && !flag_rst |=> stat_ff[EV_CAPT_BIT];
	endproperty
	a_cont: assert property (p_cont) else $error("continuous capture missed"); // R5

	property p_nshot;
		(ns_ff == NS_SKIP) && ev_capt |-> (skip_cnt_ff == ign_cnt) ##1 (ns_ff == NS_DONE || !mode[1]);
	endproperty
	a_nshot: assert property (p_nshot) else $error("N-shot used wrong transition"); // R6

	property p_skew;
		skew_ign |-> ({1'b0, cnt_ff} <= {1'b0, ref_ff} + {{(PER_W-1){1'b0}}, pos_win}) &&
			({1'b0, cnt_ff} + {{(PER_W-1){1'b0}}, neg_win} >= {1'b0, ref_ff}) &&
			(cnt_ff != ref_ff);
	endproperty
	a_skew: assert property (p_skew) else $error("ignored edge outside window"); // R8 R9

	property p_irq;
		|(stat_ff & mask_ff[EV_NUM-1:0]) |=> IRQ;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");

	c_capt: cover property (mode == MODE_CONT && ev_capt);
	c_nshot_done: cover property (ns_ff == NS_SKIP ##1 ns_ff == NS_DONE);
	c_skew: cover property (skew_ign);
	c_irq: cover property ($rose(IRQ));
endmodule

// ==== verification/scc_refgen.sv ====
// Behavioural model of the external clock and reference generator.
module scc_refgen (
	input wire logic clk, // Generator timing clock
	input wire logic rst, // Reset, active high
	input wire logic fire, // Start one reference pulse
	input wire logic [7:0] wid, // Pulse width in clocks
	input wire logic clk_ok, // Generator clock running
	output logic sysref, // Reference output
	output logic clk_det // Clock present indication
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] cnt_ff;

	// Pulse length counter; the line parks low between pulses
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= 8'h00;
		end else if (fire) begin
			cnt_ff <= wid;
		end else if (cnt_ff != 8'h00) begin
			cnt_ff <= cnt_ff - 8'h01;
		end
	end

	assign sysref = (cnt_ff != 8'h00);
	assign clk_det = clk_ok;
endmodule

// ==== verification/test_sysref_capture_control.sv ====
// Self-checking testbench for the reference capture control block.
module test_sysref_capture_control
	import scc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic MCLK = 1'b0;
	logic RST = 1'b1;
	logic SYSREF, CLK_DET, AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
	logic [ADDR_W-1:0] AWADDR = '0;
	logic [ADDR_W-1:0] ARADDR = '0;
	logic AWVALID = 1'b0;
	logic WVALID = 1'b0;
	logic BREADY = 1'b0;
	logic ARVALID = 1'b0;
	logic RREADY = 1'b0;
	logic [31:0] WDATA = '0;
	logic [3:0] WSTRB = 4'hf;
	logic [1:0] BRESP, RRESP;
	logic [31:0] RDATA;
	logic fire = 1'b0;
	logic clk_ok = 1'b0;
	logic [7:0] wid = 8'h04;
	logic [7:0] sel;
	int miscompares = 0;
	int total_checks = 0;
	logic [IDX_W-1:0] ridx[4] = '{IDX_CAPT_CTRL, IDX_IGN_COUNT, IDX_SKEW_WIN, IDX_IRQ_MASK};
	logic [7:0] wm[4] = '{8'h5e, 8'h0f, 8'h0f, 8'h07};
	logic [7:0] sk[5] = '{8'h00, 8'h01, 8'h01, 8'h04, 8'h0c};
	int gp[5] = '{21, 21, 22, 19, 17};
	logic xb[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

	always #25 MCLK = ~MCLK;

	scc_top #(.PER_W(8)) u_scc_top (.MCLK(MCLK), .RST(RST), .SYSREF(SYSREF), .CLK_DET(CLK_DET),
		.AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
		.WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
		.ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
		.RVALID(RVALID), .RREADY(RREADY), .IRQ(IRQ));

	scc_refgen u_scc_refgen (.clk(MCLK), .rst(RST), .fire(fire), .wid(wid), .clk_ok(clk_ok),
		.sysref(SYSREF), .clk_det(CLK_DET));

	// ************************************************************
	// Compare, bus and stimulus tasks
	// ************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d, input logic [1:0] er);
		bit aw_ok;
		bit w_ok;
		@(posedge MCLK);
		AWADDR <= {idx, 2'b00};
		WDATA <= {24'h000000, d};
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		while (!(aw_ok && w_ok)) begin
			@(posedge MCLK);
			if (!aw_ok && AWREADY === 1'b1) begin
				AWVALID <= 1'b0;
				aw_ok = 1'b1;
			end
			if (!w_ok && WREADY === 1'b1) begin
				WVALID <= 1'b0;
				w_ok = 1'b1;
			end
		end
		do @(posedge MCLK); while (BVALID !== 1'b1);
		BREADY <= 1'b0;
		chk({30'h0, BRESP}, {30'h0, er});
	endtask

	task automatic rd(input logic [IDX_W-1:0] idx, input logic [7:0] ed, input logic [1:0] er);
		@(posedge MCLK);
		ARADDR <= {idx, 2'b00};
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do @(posedge MCLK); while (ARREADY !== 1'b1);
		ARVALID <= 1'b0;
		do @(posedge MCLK); while (RVALID !== 1'b1);
		RREADY <= 1'b0;
		chk(RDATA, {24'h000000, ed});
		chk({30'h0, RRESP}, {30'h0, er});
	endtask

	// One reference pulse, then gap clocks until the next may start
	task automatic fw(input int gap, input logic [7:0] w);
		fire <= 1'b1;
		wid <= w;
		@(posedge MCLK);
		fire <= 1'b0;
		repeat (gap - 1) @(posedge MCLK);
	endtask

	// ************************************************************
	// Test sequence
	// ************************************************************
	initial begin
		repeat (5) @(posedge MCLK);
		RST <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			rd(ridx[i], 8'h00, RESP_OKAY);
			wr(ridx[i], 8'hff, RESP_OKAY);
			rd(ridx[i], wm[i], RESP_OKAY);
			wr(ridx[i], 8'h00, RESP_OKAY);
		end
		rd(IDX_IRQ_STATUS, 8'h00, RESP_OKAY);
		wr(10'h123, 8'h5a, RESP_SLVERR);
		rd(10'h123, 8'h00, RESP_SLVERR);
		rd(IDX_CLK_STATUS, 8'h00, RESP_OKAY);
		clk_ok <= 1'b1;
		repeat (4) @(posedge MCLK);
		rd(IDX_CLK_STATUS, 8'h01, RESP_OKAY);
		wr(IDX_IRQ_MASK, 8'h01, RESP_OKAY);
		// A cleared low byte strobe must leave the register alone
		WSTRB <= 4'h0;
		wr(IDX_IRQ_MASK, 8'h06, RESP_OKAY);
		WSTRB <= 4'hf;
		rd(IDX_IRQ_MASK, 8'h01, RESP_OKAY);
		fw(20, 8'h04);
		rd(IDX_IRQ_STATUS, 8'h00, RESP_OKAY);
		wr(IDX_CAPT_CTRL, 8'h42, RESP_OKAY);
		fw(20, 8'h04);
		rd(IDX_IRQ_STATUS, 8'h00, RESP_OKAY);
		chk({31'h0, IRQ}, 32'h0);
		wr(IDX_CAPT_CTRL, 8'h02, RESP_OKAY);
		fw(20, 8'h04);
		rd(IDX_IRQ_STATUS, 8'h01, RESP_OKAY);
		chk({31'h0, IRQ}, 32'h1);
		wr(IDX_IRQ_MASK, 8'h00, RESP_OKAY);
		repeat (2) @(posedge MCLK);
		chk({31'h0, IRQ}, 32'h0);
		wr(IDX_IRQ_MASK, 8'h01, RESP_OKAY);
		repeat (2) @(posedge MCLK);
		chk({31'h0, IRQ}, 32'h1);
		wr(IDX_IRQ_STATUS, 8'h01, RESP_OKAY);
		repeat (2) @(posedge MCLK);
		chk({31'h0, IRQ}, 32'h0);
		rd(IDX_IRQ_STATUS, 8'h00, RESP_OKAY);
		// Selects change only while capture is off, to avoid a spurious edge
		for (int e = 0; e < 2; e++) begin
			for (int t = 0; t < 2; t++) begin
				sel = {3'b000, t[0], e[0], 3'b000};
				wr(IDX_CAPT_CTRL, sel, RESP_OKAY);
				wr(IDX_IRQ_STATUS, 8'h07, RESP_OKAY);
				wr(IDX_CAPT_CTRL, sel | 8'h02, RESP_OKAY);
				fw(15, 8'h28);
				rd(IDX_IRQ_STATUS, {7'h00, ~t[0]}, RESP_OKAY);
				repeat (40) @(posedge MCLK);
				rd(IDX_IRQ_STATUS, 8'h01, RESP_OKAY);
			end
		end
		wr(IDX_CAPT_CTRL, 8'h02, RESP_OKAY);
		for (int i = 0; i < 5; i++) begin
			wr(IDX_SKEW_WIN, sk[i], RESP_OKAY);
			wr(IDX_IRQ_STATUS, 8'h07, RESP_OKAY);
			// Idle long enough that the first pulse is far outside any window
			repeat (30) @(posedge MCLK);
			for (int k = 0; k < 4; k++) begin
				fw(k < 2 ? 20 : (k == 2 ? gp[i] : 12), 8'h04);
			end
			rd(IDX_IRQ_STATUS, {6'h00, xb[i], 1'b1}, RESP_OKAY);
		end
		wr(IDX_SKEW_WIN, 8'h00, RESP_OKAY);
		for (int m = 2; m < 4; m++) begin
			wr(IDX_CAPT_CTRL, 8'h00, RESP_OKAY);
			wr(IDX_IGN_COUNT, 8'(4 - m), RESP_OKAY);
			wr(IDX_IRQ_STATUS, 8'h07, RESP_OKAY);
			wr(IDX_CAPT_CTRL, 8'(m << 1), RESP_OKAY);
			for (int k = 0; k < 4 - m; k++) begin
				fw(20, 8'h04);
			end
			rd(IDX_IRQ_STATUS, 8'h04, RESP_OKAY);
			fw(20, 8'h04);
			rd(IDX_IRQ_STATUS, 8'h05, RESP_OKAY);
			wr(IDX_IRQ_STATUS, 8'h07, RESP_OKAY);
			fw(20, 8'h04);
			rd(IDX_IRQ_STATUS, 8'h00, RESP_OKAY);
		end
		tally_and_finish();
	end

	// Cuts a hang short; the sequence needs under two thousand clocks
	initial begin
		repeat (20000) @(posedge MCLK);
		miscompares++;
		tally_and_finish();
	end
endmodule
